// ===== hdl/timer8_waveform_generator.sv
// 8-bit timer with normal, clear-on-compare, fast and phase-correct PWM modes
// Function
// - Fast PWM action 2 non-inverted, 3 inverted
// - Wave reaches pin only when pin output
// - Fast PWM: match action, opposite at wrap
// - Fast PWM period 256 prescaled ticks
// - Fast PWM: compare 0 spike, MAX constant
// - Mode 1 counts up then down
// - Phase PWM: up match clears, down sets
// - Eight bits, MAX held one tick
// - Phase PWM overflow flag at BOTTOM
// - Phase PWM period 510 ticks
// - Phase PWM: compare 0 low, MAX high
// - Missed up match level applied anyway
// - Synchronous, tick is a clock enable
// - Force strobe makes match in non-PWM modes
// - Force sets no flag, clears no counter
// - Force bit always reads zero
// - Mode bits 3 and 6, TOP rules
// - Compare update timing and overflow point
// - Clock select: stop, prescale, external edges
// - Non-PWM actions: off, toggle, clear, set
// - Compare at TOP ignored, action at TOP
// - Counter write blocks next tick match
`timescale 1ns/1ns
`include "timer8_cfg.svh"

module timer8_waveform_generator (
    // Clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [7:0]              haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hready,
    input  wire logic [31:0]             hwdata,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // External count input
    input  wire logic                    ext_count_in,
    // Waveform pin
    output timer8_pkg::pin_drive_t       pin_drive,
    output logic                         wave_out
);
    import timer8_pkg::*;

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic                  wr_pend_q;
    logic [7:0]            wr_addr_q;
    logic [31:0]           rdata_q;
    logic                  addr_ok;
    logic                  rd_take;
    logic                  wr_ctrl;
    logic                  wr_count;
    logic                  wr_cmp;
    logic                  wr_flags;
    logic                  wr_pin;
    logic [7:0]            wbyte;
    logic [7:0]            rd_byte;

    timer_control_t        ctrl_q;
    logic [7:0]            count_q;
    logic [7:0]            cmp_buf_q;
    logic [7:0]            cmp_act_q;
    logic                  ovf_q;
    logic                  match_q;
    logic                  pin_dir_q;
    logic                  pin_data_q;
    logic                  wave_q;
    logic                  down_q;
    logic                  up_hit_q;
    logic                  block_q;
    logic [`PRE_W-1:0]     pre_q;
    logic                  ext_q;

    // Address phase acceptance
    assign addr_ok  = hsel && hready && (htrans == `HTRANS_NONSEQ);
    assign rd_take  = addr_ok && !hwrite;
    assign wbyte    = hwdata[7:0];

    // Write strobes in the data phase
    assign wr_ctrl  = wr_pend_q && (wr_addr_q == `OFS_CONTROL);
    assign wr_count = wr_pend_q && (wr_addr_q == `OFS_COUNT);
    assign wr_cmp   = wr_pend_q && (wr_addr_q == `OFS_COMPARE);
    assign wr_flags = wr_pend_q && (wr_addr_q == `OFS_FLAGS);
    assign wr_pin   = wr_pend_q && (wr_addr_q == `OFS_PIN);

    // Read multiplexer; unmapped reads return zero
    always_comb begin
        if (haddr == `OFS_CONTROL) begin
            rd_byte = {1'b0, ctrl_q[6:0]};
        end else if (haddr == `OFS_COUNT) begin
            rd_byte = count_q;
        end else if (haddr == `OFS_COMPARE) begin
            rd_byte = cmp_buf_q;
        end else if (haddr == `OFS_FLAGS) begin
            rd_byte = {6'h00, match_q, ovf_q};
        end else if (haddr == `OFS_PIN) begin
            rd_byte = {6'h00, pin_data_q, pin_dir_q};
        end else begin
            rd_byte = `BYTE_ZERO;
        end
    end

    // Capture write address and read data at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= `BYTE_ZERO;
            rdata_q   <= `WORD_ZERO;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr;
            end
            if (rd_take) begin
                rdata_q <= {24'h000000, rd_byte};
            end
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ************************************************************
    // Mode decode and timer tick
    // ************************************************************
    wave_mode_t            mode;
    logic                  pwm_mode;
    logic                  tick;
    logic                  ext_rise;
    logic                  ext_fall;
    logic [1:0]            act;

    assign mode     = wave_mode_t'({ctrl_q.wave_mode_high, ctrl_q.wave_mode_low});
    assign pwm_mode = (mode == MODE_PHASE_PWM) || (mode == MODE_FAST_PWM);
    assign act      = ctrl_q.output_action_field;
    assign ext_rise = ext_count_in && !ext_q;
    assign ext_fall = !ext_count_in && ext_q;

    // Tick selection acts as the clock enable of the counter
    always_comb begin
        case (ctrl_q.clock_select_field)
            `CS_DIV1:     tick = 1'b1;
            `CS_DIV8:     tick = ((pre_q & `PRE_END_8) == `PRE_END_8);
            `CS_DIV64:    tick = ((pre_q & `PRE_END_64) == `PRE_END_64);
            `CS_DIV256:   tick = ((pre_q & `PRE_END_256) == `PRE_END_256);
            `CS_DIV1024:  tick = (pre_q == `PRE_END_1024);
            `CS_EXT_FALL: tick = ext_fall;
            `CS_EXT_RISE: tick = ext_rise;
            default:      tick = 1'b0;
        endcase
    end

    // Free prescaler and external edge history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= `PRE_ZERO;
            ext_q <= 1'b0;
        end else begin
            pre_q <= pre_q + `PRE_ONE;
            ext_q <= ext_count_in;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    logic                  at_max;
    logic                  at_bottom;
    logic                  cmp_eq;
    logic                  match;
    logic                  ctc_clear;
    logic                  pc_top;
    logic                  pc_bottom;
    logic                  ovf_evt;
    logic [7:0]            count_d;

    assign at_max    = (count_q == `CNT_MAX);
    assign at_bottom = (count_q == `CNT_BOTTOM);
    assign cmp_eq    = (count_q == cmp_act_q);
    assign match     = tick && cmp_eq && !block_q;
    assign ctc_clear = (mode == MODE_CLEAR_CMP) && cmp_eq;
    assign pc_top    = (mode == MODE_PHASE_PWM) && !down_q && at_max;
    assign pc_bottom = (mode == MODE_PHASE_PWM) && down_q && at_bottom;
    assign ovf_evt   = tick && ((mode == MODE_PHASE_PWM) ? pc_bottom : at_max);

    // Next count on a tick
    always_comb begin
        if (mode == MODE_PHASE_PWM) begin
            if (pc_top) begin
                count_d = count_q - `CNT_ONE;
            end else if (pc_bottom) begin
                count_d = count_q + `CNT_ONE;
            end else if (down_q) begin
                count_d = count_q - `CNT_ONE;
            end else begin
                count_d = count_q + `CNT_ONE;
            end
        end else if (ctc_clear) begin
            count_d = `CNT_BOTTOM;
        end else begin
            count_d = count_q + `CNT_ONE;
        end
    end

    // Count register, direction and match blocking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= `CNT_BOTTOM;
            down_q  <= 1'b0;
            block_q <= 1'b0;
        end else begin
            if (wr_count) begin
                count_q <= wbyte;
            end else if (tick) begin
                count_q <= count_d;
            end
            if (mode != MODE_PHASE_PWM) begin
                down_q <= 1'b0;
            end else if (tick && (pc_top || pc_bottom)) begin
                down_q <= !down_q;
            end
            if (wr_count) begin
                block_q <= 1'b1;
            end else if (tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // Compare buffer and the value in use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_buf_q <= `BYTE_ZERO;
            cmp_act_q <= `BYTE_ZERO;
        end else begin
            if (wr_cmp) begin
                cmp_buf_q <= wbyte;
            end
            if (!pwm_mode) begin
                cmp_act_q <= wr_cmp ? wbyte : cmp_buf_q;
            end else if (tick && pc_top) begin
                cmp_act_q <= cmp_buf_q;
            end else if (tick && (mode == MODE_FAST_PWM) && at_max) begin
                cmp_act_q <= cmp_buf_q;
            end
        end
    end

    // ************************************************************
    // Control, flags and pin registers
    // ************************************************************
    logic                  force_hit;
    logic [1:0]            force_act;

    // Force strobe needs a non-PWM mode both in the byte written with it and in the current mode, uses the written action and is never stored
    assign force_hit = wr_ctrl && wbyte[`BIT_FORCE] && !wbyte[`BIT_MODE_LOW];
    assign force_act = force_hit ? wbyte[`BIT_ACTION_HI:`BIT_ACTION_LO] : act;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q     <= timer_control_t'(`CTRL_RESET);
            pin_dir_q  <= 1'b0;
            pin_data_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= timer_control_t'({1'b0, wbyte[6:0]});
            end
            if (wr_pin) begin
                pin_dir_q  <= wbyte[`BIT_PIN_DIR];
                pin_data_q <= wbyte[`BIT_PIN_DATA];
            end
        end
    end

    // Sticky flags; write one clears, a new event wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_q   <= 1'b0;
            match_q <= 1'b0;
        end else begin
            if (ovf_evt) begin
                ovf_q <= 1'b1;
            end else if (wr_flags && wbyte[`BIT_OVF_FLAG]) begin
                ovf_q <= 1'b0;
            end
            if (match) begin
                match_q <= 1'b1;
            end else if (wr_flags && wbyte[`BIT_MATCH_FLAG]) begin
                match_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Waveform generator
    // ************************************************************
    logic                  cmp_top;
    logic                  wave_d;
    logic                  up_hit_d;

    assign cmp_top = act[1] && (cmp_act_q == `CNT_MAX);

    always_comb begin
        wave_d   = wave_q;
        up_hit_d = up_hit_q;
        if (mode == MODE_FAST_PWM) begin
            if (tick && at_max && act[1]) begin
                wave_d = !act[0];
            end else if (match && act[1] && !cmp_top) begin
                wave_d = act[0];
            end
        end else if (mode == MODE_PHASE_PWM) begin
            if (tick && pc_bottom) begin
                up_hit_d = 1'b0;
            end
            if (tick && pc_top && act[1]) begin
                if (cmp_top) begin
                    wave_d = !act[0];
                end else if (!up_hit_q) begin
                    wave_d = act[0];
                end
            end else if (match && act[1] && !cmp_top) begin
                wave_d = (down_q && !pc_bottom) ? !act[0] : act[0];
                if (!down_q || pc_bottom) begin              // BOTTOM match opens the up slope
                    up_hit_d = 1'b1;
                end
            end
        end else if (match || force_hit) begin
            case (force_act)
                2'h1:    wave_d = !wave_q;
                2'h2:    wave_d = 1'b0;
                2'h3:    wave_d = 1'b1;
                default: wave_d = wave_q;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wave_q   <= 1'b0;
            up_hit_q <= 1'b0;
        end else begin
            wave_q   <= wave_d;
            up_hit_q <= up_hit_d;
        end
    end

    // Pin mux: wave drives only with action set and direction output
    assign wave_out          = wave_q;
    assign pin_drive.pin_oe  = pin_dir_q;
    assign pin_drive.pin_out = (act != 2'h0) ? wave_q : pin_data_q;

endmodule

// ===== hdl/timer8_cfg.svh
// Constants for the 8-bit waveform timer: offsets, fields, limits and reset values
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

// ************************************************************
// Register byte offsets on the bus
// ************************************************************
`define OFS_CONTROL      8'h00
`define OFS_COUNT        8'h04
`define OFS_COMPARE      8'h08
`define OFS_FLAGS        8'h0C
`define OFS_PIN          8'h10

// ************************************************************
// Field positions
// ************************************************************
`define BIT_FORCE        7
`define BIT_MODE_LOW     6
`define BIT_ACTION_HI    5
`define BIT_ACTION_LO    4
`define BIT_MODE_HIGH    3
`define BIT_OVF_FLAG     0
`define BIT_MATCH_FLAG   1
`define BIT_PIN_DIR      0
`define BIT_PIN_DATA     1

// ************************************************************
// Counter limits and reset values
// ************************************************************
`define CNT_MAX          8'hFF
`define CNT_BOTTOM       8'h00
`define CNT_ONE          8'h01
`define CTRL_RESET       8'h00
`define BYTE_ZERO        8'h00
`define WORD_ZERO        32'h0000_0000

// ************************************************************
// Prescaler: terminal counts for divide by 8, 64, 256 and 1024
// ************************************************************
`define PRE_W            10
`define PRE_ZERO         10'h000
`define PRE_ONE          10'h001
`define PRE_END_8        10'h007
`define PRE_END_64       10'h03F
`define PRE_END_256      10'h0FF
`define PRE_END_1024     10'h3FF

// ************************************************************
// Clock select codes
// ************************************************************
`define CS_STOP          3'h0
`define CS_DIV1          3'h1
`define CS_DIV8          3'h2
`define CS_DIV64         3'h3
`define CS_DIV256        3'h4
`define CS_DIV1024       3'h5
`define CS_EXT_FALL      3'h6
`define CS_EXT_RISE      3'h7

// ************************************************************
// AHB transfer codes
// ************************************************************
`define HTRANS_NONSEQ    2'h2
`define HSIZE_WORD       3'h2

`endif

// ===== hdl/timer8_pkg.sv
// Types shared by the 8-bit waveform timer
package timer8_pkg;

    // Wave mode field decoded as {high, low}
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PHASE_PWM,
        MODE_CLEAR_CMP,
        MODE_FAST_PWM
    } wave_mode_t;

    // Control register layout
    typedef struct packed {
        logic       force_compare_strobe;
        logic       wave_mode_low;
        logic [1:0] output_action_field;
        logic       wave_mode_high;
        logic [2:0] clock_select_field;
    } timer_control_t;

    // Pin group towards the port
    typedef struct packed {
        logic pin_out;
        logic pin_oe;
    } pin_drive_t;

endpackage

// ===== tb/timer8_chk.sv
// Port checker for the 8-bit waveform timer
`timescale 1ns/1ns
`include "timer8_cfg.svh"
module timer8_chk (
    // Clock and reset
    input wire logic                    hclk,
    input wire logic                    hresetn,
    // Bus
    input wire logic                    hsel,
    input wire logic [7:0]              haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic                    hready,
    input wire logic [31:0]             hwdata,
    input wire logic [31:0]             hrdata,
    // Waveform
    input wire timer8_pkg::pin_drive_t  pin_drive,
    input wire logic                    wave_out
);
    import timer8_pkg::*;
    // Bus phase tracking, register shadows and quiet-time counter
    logic        wr_q;
    logic        rd_q;
    logic [7:0]  adr_q;
    logic [7:0]  ctl_q;
    logic [7:0]  cmp_q;
    logic [7:0]  pin_q;
    logic [10:0] quiet_q;
    wire         take  = hsel & hready & (htrans == `HTRANS_NONSEQ);
    wire  [1:0]  act   = ctl_q[5:4];
    wire         fast  = ctl_q[3] & ctl_q[6];
    wire         phase = !ctl_q[3] & ctl_q[6];
    wire         idle  = (quiet_q >= 11'h4C4) && (ctl_q[2:0] == `CS_DIV1) && act[1];

    // Shadows follow writes at the end of their data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            adr_q   <= 8'h00;
            ctl_q   <= 8'h00;
            cmp_q   <= 8'h00;
            pin_q   <= 8'h00;
            quiet_q <= 11'h000;
        end else begin
            wr_q    <= take & hwrite;
            rd_q    <= take & !hwrite;
            if (take) adr_q <= haddr;
            if (wr_q && adr_q == `OFS_CONTROL) ctl_q <= hwdata[7:0];
            if (wr_q && adr_q == `OFS_COMPARE) cmp_q <= hwdata[7:0];
            if (wr_q && adr_q == `OFS_PIN) pin_q <= hwdata[7:0];
            quiet_q <= wr_q ? 11'h000 : quiet_q + {10'h000, quiet_q != 11'h7FF};
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Assertions on the block's outputs
    strobe_reads_a: assert property (rd_q && adr_q == `OFS_CONTROL |-> hrdata[31:7] == 25'h0)
        else $error("Control read shows bits above the mode field");
    pin_select_a: assert property (pin_drive.pin_out == ((act != 2'h0) ? wave_out : pin_q[1]))
        else $error("Pin level does not follow wave or port data");
    pin_dir_a: assert property (pin_drive.pin_oe == pin_q[0])
        else $error("Pin enable differs from direction bit");
    stop_hold_a: assert property (ctl_q[2:0] == `CS_STOP && !wr_q |=> $stable(wave_out))
        else $error("Wave moved while timer stopped");
    fast_period_a: assert property (fast && idle |-> wave_out == $past(wave_out, 256))
        else $error("Fast pulse period is not 256 ticks");
    phase_period_a: assert property (phase && idle |-> wave_out == $past(wave_out, 510))
        else $error("Phase pulse period is not 510 ticks");
    phase_low_a: assert property (phase && idle && cmp_q == 8'h00 |-> wave_out == act[0])
        else $error("Phase output not constant at compare zero");
    phase_high_a: assert property (phase && idle && cmp_q == `CNT_MAX |-> wave_out == !act[0])
        else $error("Phase output not constant at compare max");
    fast_max_a: assert property (fast && idle && cmp_q == `CNT_MAX |-> wave_out == !act[0])
        else $error("Fast output not constant at compare max");

    // Main scenarios reached
    fast_run_c: cover property (fast && idle && cmp_q == 8'h40);
    phase_run_c: cover property (phase && idle);
    force_c: cover property (wr_q && adr_q == `OFS_CONTROL && hwdata[7]);
endmodule

bind timer8_waveform_generator timer8_chk timer8_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .hrdata, .pin_drive, .wave_out);

// ===== tb/timer8_waveform_generator_tb.sv
// Self-checking testbench for the 8-bit waveform timer
`timescale 1ns/1ns
`include "timer8_cfg.svh"
module timer8_waveform_generator_tb;
    import timer8_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, wave_out;
    logic        ext_count_in, ext_run;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    pin_drive_t  pin_drive;
    int          bad_count, num_checks;

    timer8_waveform_generator timer8_waveform_generator_i (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .ext_count_in, .pin_drive, .wave_out);

    // Clock and external count source
    always #10 hclk = ~hclk;
    always @(posedge hclk) if (ext_run) ext_count_in <= ~ext_count_in;

    task give_verdict;
        $display("Checks made: %0d, mismatches: %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task fail_wait;
        bad_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        give_verdict();
    endtask

    // One bus edge with ready high, bounded
    task ready_edge;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) fail_wait();
            @(posedge hclk);
        end
    endtask

    // Single word transfer: address phase, then data phase
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= `HTRANS_NONSEQ;
        hwrite <= wr;
        ready_edge();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        ready_edge();
        rd = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task step(inout int n);
        n++;
        if (n > 20000) fail_wait();
        @(negedge hclk);
    endtask

    // High time and period of the wave, in clock cycles
    task measure(output int hi, output int per);
        int n;
        n = 0;
        @(negedge hclk);
        while (wave_out !== 1'b0) step(n);
        while (wave_out !== 1'b1) step(n);
        hi = 0;
        while (wave_out === 1'b1) begin
            hi++;
            step(n);
        end
        per = hi;
        while (wave_out === 1'b0) begin
            per++;
            step(n);
        end
    endtask

    task run_pwm(input logic [7:0] ctl, input logic [7:0] cmp, input int ehi, input int eper);
        int hi, per;
        wr(`OFS_COMPARE, cmp);
        wr(`OFS_CONTROL, ctl);
        repeat (2 * eper + 1200) @(posedge hclk);
        measure(hi, per);
        chk(hi, ehi);
        chk(per, eper);
    endtask

    task level(input logic [7:0] ctl, input logic [7:0] cmp, input logic e);
        int n;
        wr(`OFS_COMPARE, cmp);
        wr(`OFS_CONTROL, ctl);
        repeat (1300) @(posedge hclk);
        n = 0;
        repeat (600) begin
            @(negedge hclk);
            if (wave_out !== e) n++;
        end
        chk(n, 0);
    endtask

    task flags_set;
        wr(`OFS_FLAGS, 8'h03);
        repeat (1100) @(posedge hclk);
        rdchk(`OFS_FLAGS, 32'h3);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_reset;
        logic [7:0] ofs[6];
        ofs = '{`OFS_CONTROL, `OFS_COUNT, `OFS_COMPARE, `OFS_FLAGS, `OFS_PIN, 8'h20};
        foreach (ofs[i]) rdchk(ofs[i], 32'h0);
        chk(32'(wave_out), 32'h0);
        chk(32'(hresp), 32'h0);
    endtask

    task t_force;
        logic [7:0] ctl[4];
        logic       e[4];
        ctl = '{8'hB0, 8'h98, 8'h98, 8'hA8};
        e = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr(`OFS_PIN, 8'h01);
        wr(`OFS_COUNT, 8'h05);
        foreach (ctl[i]) begin
            wr(`OFS_CONTROL, ctl[i]);
            repeat (2) @(posedge hclk);
            chk(32'(wave_out), 32'(e[i]));
            chk(32'(pin_drive.pin_out), 32'(e[i]));
        end
        rdchk(`OFS_CONTROL, 32'h28);
        rdchk(`OFS_COUNT, 32'h5);
        rdchk(`OFS_FLAGS, 32'h0);
        wr(`OFS_CONTROL, 8'h08);
        wr(`OFS_PIN, 8'h03);
        repeat (2) @(posedge hclk);
        chk(32'(pin_drive.pin_out), 32'h1);
        wr(`OFS_PIN, 8'h02);
        repeat (2) @(posedge hclk);
        chk(32'(pin_drive.pin_oe), 32'h0);
        wr(`OFS_PIN, 8'h01);
        run_pwm(8'h19, 8'h40, 65, 130);
    endtask

    task t_fast;
        run_pwm(8'h69, 8'h40, 65, 256);
        run_pwm(8'h79, 8'h40, 191, 256);
        run_pwm(8'h69, 8'h00, 1, 256);
        flags_set();
        level(8'h69, `CNT_MAX, 1'b1);
    endtask

    task t_phase;
        run_pwm(8'h61, 8'h40, 128, 510);
        run_pwm(8'h71, 8'h40, 382, 510);
        flags_set();
        level(8'h61, 8'h00, 1'b0);
        level(8'h71, `CNT_MAX, 1'b0);
        level(8'h61, `CNT_MAX, 1'b1);
        run_pwm(8'h61, 8'h40, 128, 510);
    endtask

    task t_presc;
        ext_run = 1'b1;
        run_pwm(8'h6A, 8'h40, 520, 2048);
        run_pwm(8'h6E, 8'h40, 130, 512);
        run_pwm(8'h6F, 8'h40, 130, 512);
        wr(`OFS_CONTROL, 8'h68);
        repeat (300) @(posedge hclk);
    endtask

    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = `HSIZE_WORD;
        hwdata = 32'h0;
        ext_count_in = 1'b0;
        ext_run = 1'b0;
        bad_count = 0;
        num_checks = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_force();
        t_fast();
        t_phase();
        t_presc();
        give_verdict();
    end
endmodule
